/* rtl/store_defines.vh */
// Constants shared by the guarded displacement store unit and its helpers.
// Assumes byte addresses on a 32-bit AXI4-Lite register port, one word per register.
//
// Overview of operation
// - Halfword store writes low 16 data bits.
// - Halfword byte lanes follow byte order.
// - Odd halfword address sets misaligned flag.
// - Flag plus trap enable requests exception.
// - False guard suppresses every side effect.
// - Word store writes all 32 bits.
// - Word byte lanes follow byte order.
// - Unaligned word address sets misaligned flag.
// - Displacement comes from 7-bit modifier.
// - Byte order sampled when store executes.
`ifndef STORE_DEFINES_VH
`define STORE_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_PSW 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_MASK 8'h08
`define OFS_STORE_COUNT 8'h0c

// ****************************************************************
// Processor status word fields and reset values
// ****************************************************************
`define PSW_BIG_ENDIAN 0
`define PSW_MISALIGNED 1
`define PSW_TRAP_ENABLE 2
`define PSW_TRAP_PENDING 3
`define PSW_RESET 4'h0

// ****************************************************************
// Interrupt event bits and reset values
// ****************************************************************
`define IRQ_MISALIGNED 0
`define IRQ_TRAP 1
`define IRQ_EVENTS 2
`define IRQ_RESET 2'h0

// ****************************************************************
// Bus answers and store geometry
// ****************************************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define MODIFIER_WIDTH 7
`define LAST_HALF_BYTE 2'h1
`define LAST_WORD_BYTE 2'h3

`endif

/* rtl/store_lane_former.v */
// Byte lane former: places store data on the four lanes of an aligned word.
// Assumes a purely combinational context; the caller registers the results.
`timescale 1ns/1ps
module store_lane_former
(
   // Store description.
   input wire [1:0] addr_low,
   input wire is_word,
   input wire big_endian,
   input wire [31:0] data,
   // Lane results.
   output wire misaligned,
   output wire [3:0] byte_en,
   output wire [31:0] lane_data
);
`include "store_defines.vh"

   // Index of the last byte of the item relative to its start address.
   wire [1:0] last_byte;

   assign last_byte = is_word ? `LAST_WORD_BYTE : `LAST_HALF_BYTE;

   // A halfword needs an even address, a word one divisible by four.
   assign misaligned = is_word ? (|addr_low) : addr_low[0];

   genvar j;
   generate
      for (j = 0; j < 4; j = j + 1)
      begin : g_lane
         // Lane j holds the byte at start address plus ofs.
         wire [1:0] lane_idx;
         wire [1:0] ofs;
         wire [1:0] src;
         wire in_range;
         assign lane_idx = j;
         assign ofs = lane_idx - addr_low;
         assign in_range = (ofs <= last_byte);
         // Little endian puts data byte 0 first, big endian the top byte first.
         assign src = big_endian ? (last_byte - ofs) : ofs;
         // Misaligned results are undefined; the lanes are simply not written.
         assign byte_en[j] = in_range & ~misaligned;
         assign lane_data[8*j+7:8*j] = in_range ? data[{src, 3'b000} +: 8] : 8'h00;
      end
   endgenerate

endmodule

/* rtl/store_irq_regs.v */
// Sticky interrupt status with a mask and one level interrupt output.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
module store_irq_regs
(
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // Event pulses and software access.
   input wire [1:0] event_set,
   input wire status_we,
   input wire [1:0] status_wdata,
   input wire mask_we,
   input wire [1:0] mask_wdata,
   // State.
   output reg [1:0] status,
   output reg [1:0] mask,
   output reg irq
);
`include "store_defines.vh"

   // Next values, so the interrupt line follows the flags without lag.
   reg [1:0] next_status;
   reg [1:0] next_mask;

   // Write one clears, but an event in the same cycle wins over the clear.
   always @*
   begin
      next_status = status;
      if (status_we)
      begin
         next_status = next_status & ~status_wdata;
      end
      next_status = next_status | event_set;
      next_mask = mask_we ? mask_wdata : mask;
   end

   // Registered state and interrupt level.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status <= `IRQ_RESET;
         mask <= `IRQ_RESET;
         irq <= 1'b0;
      end
      else
      begin
         status <= next_status;
         mask <= next_mask;
         irq <= |(next_status & next_mask);
      end
   end

endmodule

/* rtl/guarded_displacement_store.v */
// Guarded store unit: halfword and word stores with a scaled 7-bit displacement.
// Assumes issue logic and the memory port share aclk; registers reached over AXI4-Lite.
`timescale 1ns/1ps
module guarded_displacement_store
#(
   parameter ADDR_W = 8
)
(
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // Store issue port.
   input wire st_valid,
   input wire st_is_word,
   input wire [31:0] store_data_operand,
   input wire [31:0] base_address_operand,
   input wire [6:0] st_modifier,
   input wire st_guard_present,
   input wire st_guard_lsb,
   output reg st_ready,
   // Interruptible jump strobe and exception request.
   input wire interruptible_jump,
   output reg exception_request,
   // Memory write port.
   output reg mem_valid,
   output reg [31:0] mem_addr,
   output reg [3:0] mem_byte_en,
   output reg [31:0] mem_wdata,
   input wire mem_ready,
   // AXI4-Lite write address and data.
   input wire awvalid,
   output reg awready,
   input wire [ADDR_W-1:0] awaddr,
   input wire [2:0] awprot,
   input wire wvalid,
   output reg wready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   // AXI4-Lite write response.
   output reg bvalid,
   input wire bready,
   output reg [1:0] bresp,
   // AXI4-Lite read.
   input wire arvalid,
   output reg arready,
   input wire [ADDR_W-1:0] araddr,
   input wire [2:0] arprot,
   output reg rvalid,
   input wire rready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   // Interrupt.
   output wire irq
);
`include "store_defines.vh"
   // Status word value after reset, taken apart bit by bit at its flops.
   localparam [3:0] PSW_INIT = `PSW_RESET;

   // ****************************************************************
   // State
   // ****************************************************************
   reg big_endian; // Current byte order, 1 for big endian.
   reg misaligned_store_flag; // Sticky misaligned store flag.
   reg misaligned_store_trap_enable; // Trap on misaligned store.
   reg trap_pending; // Waiting for the next interruptible jump.
   reg [31:0] store_count; // Aligned stores that took effect.
   reg aw_held; // Write address latched, waiting for data.
   reg w_held; // Write data latched, waiting for address.
   reg [ADDR_W-1:0] aw_addr_q; // Latched write address.
   reg [31:0] w_data_q; // Latched write data.
   reg [3:0] w_strb_q; // Latched write strobes.

   // ****************************************************************
   // Store datapath
   // ****************************************************************
   wire [31:0] disp; // Scaled, sign extended displacement.
   wire [31:0] store_addr; // Base plus displacement.
   wire st_take; // Store accepted this cycle.
   wire st_enabled; // Guard allows side effects.
   wire st_effect; // Accepted and enabled.
   wire lane_misaligned;
   wire [3:0] lane_byte_en;
   wire [31:0] lane_data;

   // The modifier is scaled by the access size, never read from a register.
   assign disp = st_is_word ? {{23{st_modifier[6]}}, st_modifier, 2'b00}
                            : {{24{st_modifier[6]}}, st_modifier, 1'b0};
   assign store_addr = base_address_operand + disp;
   // Issue logic keeps the modifier legal, so the scaled ranges hold by construction.
   assign st_take = st_valid & st_ready;
   // Without a guard the store always acts; with one only its low bit counts.
   assign st_enabled = ~st_guard_present | st_guard_lsb;
   assign st_effect = st_take & st_enabled;

   // Byte order is the status word value in the cycle the store is taken.
   store_lane_former u_lanes
   (
      .addr_low(store_addr[1:0]),
      .is_word(st_is_word),
      .big_endian(big_endian),
      .data(store_data_operand),
      .misaligned(lane_misaligned),
      .byte_en(lane_byte_en),
      .lane_data(lane_data)
   );

   // Misalignment is an event only for a store that takes effect.
   wire mis_event;
   wire trap_event;
   assign mis_event = st_effect & lane_misaligned;
   assign trap_event = mis_event & misaligned_store_trap_enable;

   // Memory output register; a held write stalls the issue port.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mem_valid <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_byte_en <= 4'h0;
         mem_wdata <= 32'h0000_0000;
         st_ready <= 1'b0;
      end
      else
      begin
         // Ready drops while a write is outstanding, so nothing is overwritten.
         st_ready <= ~(mem_valid & ~mem_ready) & ~(st_effect & ~lane_misaligned);
         if (st_effect & ~lane_misaligned)
         begin
            // Guarded-off and misaligned stores never reach memory.
            mem_valid <= 1'b1;
            mem_addr <= {store_addr[31:2], 2'b00};
            mem_byte_en <= lane_byte_en;
            mem_wdata <= lane_data;
         end
         else if (mem_ready)
         begin
            mem_valid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Register write path
   // ****************************************************************
   wire [ADDR_W-1:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire wr_fire; // Address and data both present, response free.
   wire wr_psw;
   wire wr_status;
   wire wr_mask;
   wire wr_known;

   // Either half may come first; the latched copy fills in the other.
   assign wr_addr = aw_held ? aw_addr_q : awaddr;
   assign wr_data = w_held ? w_data_q : wdata;
   assign wr_strb = w_held ? w_strb_q : wstrb;
   assign wr_fire = (aw_held | (awvalid & awready)) & (w_held | (wvalid & wready));
   assign wr_psw = wr_fire & (wr_addr == `OFS_PSW) & wr_strb[0];
   assign wr_status = wr_fire & (wr_addr == `OFS_IRQ_STATUS) & wr_strb[0];
   assign wr_mask = wr_fire & (wr_addr == `OFS_IRQ_MASK) & wr_strb[0];
   assign wr_known = (wr_addr == `OFS_PSW) | (wr_addr == `OFS_IRQ_STATUS) |
                     (wr_addr == `OFS_IRQ_MASK) | (wr_addr == `OFS_STORE_COUNT);

   // Write channel handshakes and the response.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b0;
         wready <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= {ADDR_W{1'b0}};
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end
      else
      begin
         if (wr_fire)
         begin
            // The store count is read only; writing it is accepted and ignored.
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end
         else
         begin
            if (awvalid & awready)
            begin
               aw_held <= 1'b1;
               aw_addr_q <= awaddr;
            end
            if (wvalid & wready)
            begin
               w_held <= 1'b1;
               w_data_q <= wdata;
               w_strb_q <= wstrb;
            end
            bvalid <= bvalid & ~bready;
            // Readiness returns only once the previous response is gone.
            awready <= ~aw_held & ~(awvalid & awready) & ~(bvalid & ~bready);
            wready <= ~w_held & ~(wvalid & wready) & ~(bvalid & ~bready);
         end
      end
   end

   // ****************************************************************
   // Status word, trap request and store count
   // ****************************************************************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         big_endian <= PSW_INIT[`PSW_BIG_ENDIAN];
         misaligned_store_flag <= PSW_INIT[`PSW_MISALIGNED];
         misaligned_store_trap_enable <= PSW_INIT[`PSW_TRAP_ENABLE];
         trap_pending <= PSW_INIT[`PSW_TRAP_PENDING];
         exception_request <= 1'b0;
         store_count <= 32'h0000_0000;
      end
      else
      begin
         if (wr_psw)
         begin
            big_endian <= wr_data[`PSW_BIG_ENDIAN];
            misaligned_store_trap_enable <= wr_data[`PSW_TRAP_ENABLE];
         end
         // The flag is cleared by writing one, but a new misaligned store wins.
         misaligned_store_flag <= mis_event |
                                  (misaligned_store_flag & ~(wr_psw & wr_data[`PSW_MISALIGNED]));
         // A request made in the jump cycle itself waits for the following jump.
         exception_request <= interruptible_jump & trap_pending;
         trap_pending <= trap_event | (trap_pending & ~interruptible_jump);
         if (st_effect & ~lane_misaligned)
         begin
            store_count <= store_count + 32'h0000_0001;
         end
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   wire [1:0] irq_status;
   wire [1:0] irq_mask;

   store_irq_regs u_irq
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .event_set({trap_event, mis_event}),
      .status_we(wr_status),
      .status_wdata(wr_data[1:0]),
      .mask_we(wr_mask),
      .mask_wdata(wr_data[1:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // ****************************************************************
   // Register read path
   // ****************************************************************
   reg [31:0] rd_value; // Word selected by the read address.
   reg rd_known; // Read address is mapped.

   // Read multiplexer; unmapped addresses return zero with an error.
   always @*
   begin
      rd_known = 1'b1;
      rd_value = 32'h0000_0000;
      case (araddr)
         `OFS_PSW:
         begin
            rd_value = {28'h0000000, trap_pending, misaligned_store_trap_enable,
                        misaligned_store_flag, big_endian};
         end
         `OFS_IRQ_STATUS:
         begin
            rd_value = {30'h0, irq_status};
         end
         `OFS_IRQ_MASK:
         begin
            rd_value = {30'h0, irq_mask};
         end
         `OFS_STORE_COUNT:
         begin
            rd_value = store_count;
         end
         default:
         begin
            rd_known = 1'b0;
         end
      endcase
   end

   // Read channel: one read in flight, data held until taken.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= `RESP_OKAY;
      end
      else
      begin
         if (arvalid & arready)
         begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_value;
            rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (rvalid & rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
         else
         begin
            arready <= ~rvalid;
         end
      end
   end

endmodule

/* testbench/store_unit_monitor.sv */
// Port checker for the guarded store unit.
// Assumes one clock, aclk, and a synchronous active-low aresetn.
`timescale 1ns/1ps
module store_unit_monitor
#(
   parameter ADDR_W = 8
)
(
   // Clock and reset.
   input wire aclk,
   input wire aresetn,
   // Store issue port.
   input wire st_valid,
   input wire st_ready,
   input wire st_is_word,
   input wire [31:0] store_data_operand,
   input wire [31:0] base_address_operand,
   input wire [6:0] st_modifier,
   input wire st_guard_present,
   input wire st_guard_lsb,
   // Trap.
   input wire interruptible_jump,
   input wire exception_request,
   // Memory write port.
   input wire mem_valid,
   input wire [31:0] mem_addr,
   input wire [3:0] mem_byte_en,
   input wire [31:0] mem_wdata,
   input wire mem_ready
);
   // ****************************************************************
   // Expected store, worked out from the issue port
   // ****************************************************************
   wire [31:0] d = store_data_operand;
   wire [31:0] disp = st_is_word ? {{23{st_modifier[6]}}, st_modifier, 2'b00}
                                 : {{24{st_modifier[6]}}, st_modifier, 1'b0};
   wire [31:0] addr = base_address_operand + disp;
   wire take = st_valid & st_ready;
   wire enabled = !st_guard_present | st_guard_lsb;
   wire aligned = st_is_word ? (addr[1:0] == 2'b00) : !addr[0];
   wire launch = take & enabled & aligned;
   wire [31:0] lane_mask = {{8{mem_byte_en[3]}}, {8{mem_byte_en[2]}}, {8{mem_byte_en[1]}}, {8{mem_byte_en[0]}}};
   reg [31:0] exp_addr;
   reg [3:0] exp_lanes;
   reg [31:0] exp_le;
   reg [31:0] exp_be;
   // Captured at each take, since the operands may change right after it.
   always @(posedge aclk)
   begin
      if (take)
      begin
         exp_addr <= {addr[31:2], 2'b00};
         exp_lanes <= st_is_word ? 4'hf : (addr[1] ? 4'hc : 4'h3);
         exp_le <= st_is_word ? d : (addr[1] ? {d[15:0], 16'h0} : {16'h0, d[15:0]});
         exp_be <= st_is_word ? {d[7:0], d[15:8], d[23:16], d[31:24]} :
                   (addr[1] ? {d[7:0], d[15:8], 16'h0} : {16'h0, d[7:0], d[15:8]});
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   AST_STORE_LAUNCH: assert property (launch |=> mem_valid
      && mem_addr == exp_addr && mem_byte_en == exp_lanes)
      else $error("store did not reach memory at the computed address");
   AST_LANE_DATA: assert property (launch |=> (mem_wdata & lane_mask) == exp_le
      || (mem_wdata & lane_mask) == exp_be)
      else $error("store bytes in wrong lanes");
   AST_GUARD_OFF_SILENT: assert property (take && !enabled |=> !mem_valid)
      else $error("store with false guard reached memory");
   AST_MISALIGNED_NO_WRITE: assert property (take && enabled && !aligned |=> !mem_valid)
      else $error("misaligned store reached memory");
   AST_MEM_HOLD: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr)
      && $stable(mem_wdata) && $stable(mem_byte_en))
      else $error("memory request changed before acceptance");
   AST_EXC_ONE_CYCLE: assert property (exception_request |=> !exception_request)
      else $error("exception request longer than one cycle");
   AST_EXC_AFTER_JUMP: assert property ($rose(exception_request) |-> $past(interruptible_jump))
      else $error("exception request without an interruptible jump");
   AST_LANE_SHAPE: assert property (mem_valid |-> mem_byte_en == 4'hf
      || mem_byte_en == 4'h3 || mem_byte_en == 4'hc)
      else $error("byte enables are not a halfword or word");
   // Main scenarios are reached.
   cover property (launch && st_is_word);
   cover property (exception_request);
   cover property (mem_valid && !mem_ready);
endmodule

bind guarded_displacement_store store_unit_monitor #(.ADDR_W(ADDR_W)) u_store_unit_monitor (.aclk(aclk),
   .aresetn(aresetn), .st_valid(st_valid), .st_ready(st_ready), .st_is_word(st_is_word),
   .store_data_operand(store_data_operand), .base_address_operand(base_address_operand),
   .st_modifier(st_modifier), .st_guard_present(st_guard_present), .st_guard_lsb(st_guard_lsb),
   .interruptible_jump(interruptible_jump), .exception_request(exception_request), .mem_valid(mem_valid),
   .mem_addr(mem_addr), .mem_byte_en(mem_byte_en), .mem_wdata(mem_wdata), .mem_ready(mem_ready));

/* testbench/mem_partner.sv */
// Memory partner: a byte array behind the store unit's write port.
// Assumes word-aligned addresses with byte enables; wait states set by the bench.
`timescale 1ns/1ps
module mem_partner
(
   // Clock and write request.
   input wire aclk,
   input wire mem_valid,
   input wire [31:0] mem_addr,
   input wire [3:0] mem_byte_en,
   input wire [31:0] mem_wdata,
   // Answer and wait states.
   output wire mem_ready,
   input wire [2:0] stall
);
   reg [7:0] mem [0:4095];
   reg [2:0] waited = 3'h0;
   integer i;
   integer j;
   // Ready only after the requested wait states, so slow answers are exercised.
   assign mem_ready = mem_valid && (waited >= stall);
   // A fill pattern makes untouched bytes recognisable.
   initial
   begin
      for (j = 0; j < 4096; j = j + 1)
         mem[j] = 8'h5a;
   end
   // Bytes land only at the accepting edge.
   always @(posedge aclk)
   begin
      waited <= (mem_valid && !mem_ready) ? waited + 3'h1 : 3'h0;
      for (i = 0; i < 4; i = i + 1)
         if (mem_ready && mem_byte_en[i])
            mem[mem_addr[11:0] + i] <= mem_wdata[8*i +: 8];
   end
endmodule

/* testbench/test_guarded_displacement_store.sv */
// Bench for the guarded store unit: stores, byte order, guards, traps, registers.
// Assumes the memory partner and the port checker are compiled before it.
`timescale 1ns/1ps
`include "store_defines.vh"
module test_guarded_displacement_store;
   // ****************************************************************
   // Signals
   // ****************************************************************
   reg aclk = 0;
   reg aresetn = 0;
   reg st_valid = 0, st_is_word = 0, gp = 0, gl = 0, ij = 0;
   reg [31:0] sd = 0, sb = 0, wdata = 0;
   reg [6:0] sm = 0;
   reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   reg [7:0] awaddr = 0, araddr = 0;
   reg [2:0] stall = 0;
   wire st_ready, exc, mv, mr, awready, wready, bvalid, arready, rvalid, irq;
   wire [31:0] ma, mw, rdata;
   wire [3:0] me;
   wire [1:0] bresp, rresp;
   integer bad_count = 0, checks = 0, cycles = 0, i;
   always #2.5 aclk = ~aclk;
   guarded_displacement_store u_guarded_displacement_store (.aclk(aclk), .aresetn(aresetn), .st_valid(st_valid),
      .st_is_word(st_is_word), .store_data_operand(sd), .base_address_operand(sb), .st_modifier(sm),
      .st_guard_present(gp), .st_guard_lsb(gl), .st_ready(st_ready), .interruptible_jump(ij),
      .exception_request(exc), .mem_valid(mv), .mem_addr(ma), .mem_byte_en(me), .mem_wdata(mw),
      .mem_ready(mr), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
      .rdata(rdata), .rresp(rresp), .irq(irq));
   mem_partner u_mem_partner (.aclk(aclk), .mem_valid(mv), .mem_addr(ma), .mem_byte_en(me), .mem_wdata(mw),
      .mem_ready(mr), .stall(stall));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task chk(input string n, input [31:0] e, input [31:0] g);
      begin
         checks = checks + 1;
         if (g !== e)
         begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task mb(input [11:0] a, input [7:0] e);
      chk("memory byte", {24'h0, e}, {24'h0, u_mem_partner.mem[a]});
   endtask
   // Offer one store, hold it until taken, then wait for memory to let go.
   task st(input w, input [31:0] d, input [31:0] b, input [6:0] m, input p, input l);
      begin
         @(posedge aclk);
         {st_valid, st_is_word, sd, sb, sm, gp, gl} <= {1'b1, w, d, b, m, p, l};
         @(posedge aclk);
         while (st_ready !== 1'b1)
            @(posedge aclk);
         st_valid <= 0;
         @(posedge aclk);
         while (mv === 1'b1)
            @(posedge aclk);
      end
   endtask
   // Register write: address and data offered together, each released when taken.
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge aclk);
         {awvalid, wvalid, bready, awaddr, wdata} <= {3'b111, a, d};
         @(posedge aclk);
         while (bvalid !== 1'b1)
         begin
            if (awready === 1'b1)
               awvalid <= 0;
            if (wready === 1'b1)
               wvalid <= 0;
            @(posedge aclk);
         end
         bready <= 0;
         chk("bresp", (a > `OFS_STORE_COUNT) ? 32'h2 : 32'h0, {30'h0, bresp});
      end
   endtask
   task rd(input [7:0] a, input [31:0] e, input [1:0] er);
      begin
         @(posedge aclk);
         {arvalid, rready, araddr} <= {2'b11, a};
         @(posedge aclk);
         while (rvalid !== 1'b1)
         begin
            if (arready === 1'b1)
               arvalid <= 0;
            @(posedge aclk);
         end
         rready <= 0;
         chk("rdata", e, rdata);
         chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
   endtask
   // One jump pulse; the request shows in the cycle after it.
   task jump(input e);
      begin
         @(posedge aclk);
         ij <= 1;
         @(posedge aclk);
         ij <= 0;
         @(posedge aclk);
         chk("exception_request", {31'h0, e}, {31'h0, exc});
      end
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task t_regs;
      begin
         rd(`OFS_PSW, 32'h0, 2'h0);
         rd(`OFS_IRQ_STATUS, 32'h0, 2'h0);
         rd(`OFS_IRQ_MASK, 32'h0, 2'h0);
         rd(8'h10, 32'h0, 2'h2);
         wr(8'h10, 32'h1);
      end
   endtask
   task t_little;
      begin
         st(0, 32'h44332211, 32'hcfe, 7'h01, 0, 0);
         mb(12'hd00, 8'h11);
         mb(12'hd01, 8'h22);
         stall <= 3'h3;
         st(1, 32'h44332211, 32'hcfc, 7'h01, 1, 1);
         for (i = 0; i < 4; i = i + 1)
            mb(12'hd00 + i, 8'h11 * (i + 1));
      end
   endtask
   task t_big;
      begin
         wr(`OFS_PSW, 32'h1);
         st(0, 32'haabbccdd, 32'hd06, 7'h7e, 1, 1);
         mb(12'hd02, 8'hcc);
         mb(12'hd03, 8'hdd);
         st(1, 32'haabbccdd, 32'hd0c, 7'h7e, 1, 1);
         for (i = 0; i < 4; i = i + 1)
            mb(12'hd04 + i, 8'haa + 8'h11 * i);
         wr(`OFS_PSW, 32'h0);
         st(1, 32'haabbccdd, 32'hd0c, 7'h7e, 0, 0);
         mb(12'hd04, 8'hdd);
         rd(`OFS_STORE_COUNT, 32'h5, 2'h0);
      end
   endtask
   task t_guard;
      begin
         st(1, 32'h0, 32'hd00, 7'h00, 1, 0);
         mb(12'hd00, 8'h11);
         st(1, 32'h0, 32'hd0b, 7'h7e, 1, 0);
         st(0, 32'h0, 32'hd01, 7'h00, 1, 0);
         rd(`OFS_PSW, 32'h0, 2'h0);
         wr(`OFS_STORE_COUNT, 32'h0);
         rd(`OFS_STORE_COUNT, 32'h5, 2'h0);
      end
   endtask
   task t_trap;
      begin
         wr(`OFS_PSW, 32'h4);
         jump(0);
         st(0, 32'h1234, 32'hd01, 7'h00, 0, 0);
         rd(`OFS_PSW, 32'he, 2'h0);
         chk("irq", 32'h0, {31'h0, irq});
         jump(1);
         rd(`OFS_PSW, 32'h6, 2'h0);
         rd(`OFS_IRQ_STATUS, 32'h3, 2'h0);
         wr(`OFS_IRQ_MASK, 32'h1);
         repeat (2) @(posedge aclk);
         chk("irq", 32'h1, {31'h0, irq});
         wr(`OFS_IRQ_STATUS, 32'h3);
         repeat (2) @(posedge aclk);
         chk("irq", 32'h0, {31'h0, irq});
         wr(`OFS_PSW, 32'h6);
         rd(`OFS_PSW, 32'h4, 2'h0);
         st(1, 32'h0, 32'hd02, 7'h00, 1, 1);
         rd(`OFS_PSW, 32'he, 2'h0);
         jump(1);
      end
   endtask
   // ****************************************************************
   // Verdict, timeout and main sequence
   // ****************************************************************
   task summarize;
      begin
         if (bad_count == 0 && checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // The whole run needs well under a thousand cycles.
   always @(posedge aclk)
   begin
      cycles = cycles + 1;
      if (cycles == 5000)
      begin
         bad_count = bad_count + 1;
         summarize;
      end
   end
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      t_regs;
      t_little;
      t_big;
      t_guard;
      t_trap;
      summarize;
   end
endmodule
